// File: tap_defines.svh
/*
  Constants of the boundary-scan test access port: instruction codes,
  capture pattern, identification field layout, synchroniser width and reset value.
  Assumes it is included by bare name after the package or in a module.
*/
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH

`define TAP_IR_WIDTH       4
`define TAP_IR_EXTEST      4'h0
`define TAP_IR_SAMPLE      4'h1
`define TAP_IR_IDCODE      4'h2
`define TAP_IR_HIGHZ       4'h3
`define TAP_IR_BYPASS      4'hF
`define TAP_IR_CAPTURE     4'h1

`define TAP_ID_WIDTH       32
`define TAP_ID_VER_MSB     31
`define TAP_ID_VER_LSB     28
`define TAP_ID_PART_MSB    27
`define TAP_ID_PART_LSB    12
`define TAP_ID_MFR_MSB     11
`define TAP_ID_MFR_LSB     1
`define TAP_ID_MARK        1'b1

`define TAP_PIN_COUNT      4
// Synchroniser starts with test clock and mode select high, serial data and test reset pin low
`define TAP_PIN_RESET      4'h3

`endif

// File: tap_pkg.sv
/*
  Types of the boundary-scan test access port: controller states and
  the selection of the test data register.
  Assumes nothing of its surroundings.
*/
package tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_type;

  typedef enum logic [1:0] {
    DR_BYPASS,
    DR_BOUNDARY,
    DR_IDENT
  } dr_sel_type;

endpackage : tap_pkg

// File: tap_pin_sync.sv
/*
  Two-stage synchroniser for a group of pins from outside the clock domain.
  Assumes a free-running clock; the first stage feeds only the second.
*/
`timescale 1ns/10ps
`default_nettype none

module tap_pin_sync #(
  parameter int          WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = i_async;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= {RESET_VAL, RESET_VAL};
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.sync;

endmodule : tap_pin_sync

`default_nettype wire

// File: tap_scan_chain.sv
/*
  Boundary-scan chain: a capture/shift stage per cell and an update latch
  that drives the cells toward the pins.
  Assumes single-cycle strobes from the controller; shift runs toward bit 0.
*/
`timescale 1ns/10ps
`default_nettype none

module tap_scan_chain #(
  parameter int LENGTH = 8
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_clk_en,
  input  wire logic              i_capture,
  input  wire logic              i_shift,
  input  wire logic              i_update,
  input  wire logic              i_sin,
  input  wire logic [LENGTH-1:0] i_par_in,
  output var  logic              o_sout,
  output var  logic [LENGTH-1:0] o_par_out
);

  typedef struct packed {
    logic [LENGTH-1:0] shift;
    logic [LENGTH-1:0] latch;
  } chain_state_type;

  chain_state_type st_reg;
  chain_state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (i_capture) begin
      st_next.shift = i_par_in;
    end else if (i_shift) begin
      st_next.shift = {i_sin, st_reg.shift[LENGTH-1:1]};
    end
    if (i_update) begin
      st_next.latch = st_reg.shift;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_sout    = st_reg.shift[0];
  assign o_par_out = st_reg.latch;

endmodule : tap_scan_chain

`default_nettype wire

// File: tap_controller.sv
/*
  Test access port of a FIFO memory: sixteen-state controller, instruction
  register, bypass, identification and boundary-scan data registers.
  Assumes the test clock and test pins are slow against I_CLOCK (at least
  three system clocks per test clock phase) and arrive asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none

`include "tap_defines.svh"

module tap_controller
  import tap_pkg::*;
#(
  parameter int          BSR_LENGTH = 8,
  parameter logic [3:0]  ID_VERSION = 4'h1,     // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'hA5C3, // Arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h2D4   // Arbitrary value
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST_B,
  input  wire logic                  I_CLK_EN,
  input  wire logic                  I_TCK,
  input  wire logic                  I_TMS,
  input  wire logic                  I_TDI,
  input  wire logic                  I_TRST_B,
  input  wire logic [BSR_LENGTH-1:0] I_BSR_CAPTURE,
  output var  logic                  O_TDO,
  output var  logic                  O_TDO_OE_B,
  output var  logic [BSR_LENGTH-1:0] O_BSR_DRIVE,
  output var  logic                  O_PIN_OVERRIDE,
  output var  logic                  O_OUTPUTS_HIZ,
  output var  logic                  O_TEST_RESET,
  output var  logic                  O_RUN_TEST_ACTIVE
);

  localparam logic [`TAP_ID_WIDTH-1:0] ID_VALUE =
    {ID_VERSION, ID_PART, ID_MAKER, `TAP_ID_MARK};

  typedef struct packed {
    tap_state_type                 state;
    logic [`TAP_IR_WIDTH-1:0]      ir_shift;
    logic [`TAP_IR_WIDTH-1:0]      ir_cur;
    logic                          bypass;
    logic [`TAP_ID_WIDTH-1:0]      id_shift;
    logic                          tck_prev;
    logic                          tdo;
    logic                          tdo_oe_b;
    logic                          pin_override;
    logic                          outputs_hiz;
    logic                          test_reset;
    logic                          run_active;
  } tap_reg_type;

  localparam tap_reg_type ST_RESET = '{
    state:        TEST_LOGIC_RESET,
    ir_shift:     `TAP_IR_IDCODE,
    ir_cur:       `TAP_IR_IDCODE,
    bypass:       1'b0,
    id_shift:     '0,
    tck_prev:     1'b1,
    tdo:          1'b0,
    tdo_oe_b:     1'b1,
    pin_override: 1'b0,
    outputs_hiz:  1'b0,
    test_reset:   1'b1,
    run_active:   1'b0
  };

  tap_reg_type st_reg;
  tap_reg_type st_next;

  logic [`TAP_PIN_COUNT-1:0] pins_sync;
  logic                      tck_s;
  logic                      tms_s;
  logic                      tdi_s;
  logic                      trst_b_s;
  logic                      tck_rise;
  logic                      tck_fall;
  dr_sel_type                dr_sel;
  logic                      bsr_capture;
  logic                      bsr_shift;
  logic                      bsr_update;
  logic                      bsr_sout;

  // Data register picked by an instruction
  function automatic dr_sel_type decode_dr(input logic [`TAP_IR_WIDTH-1:0] ir);
    dr_sel_type sel;
    sel = DR_BYPASS;
    case (ir)
      `TAP_IR_EXTEST: sel = DR_BOUNDARY;
      `TAP_IR_SAMPLE: sel = DR_BOUNDARY;
      `TAP_IR_IDCODE: sel = DR_IDENT;
      `TAP_IR_HIGHZ:  sel = DR_BYPASS;
      `TAP_IR_BYPASS: sel = DR_BYPASS;
      default:        sel = DR_BYPASS;
    endcase
    return sel;
  endfunction : decode_dr

  // Test functions switched on by an instruction
  typedef struct packed {
    logic pins;
    logic hiz;
    logic run;
  } test_ctl_type;

  function automatic test_ctl_type decode_test(input logic [`TAP_IR_WIDTH-1:0] ir);
    test_ctl_type ctl;
    ctl = '0;
    case (ir)
      `TAP_IR_EXTEST: begin
        ctl.pins = 1'b1;
        ctl.run  = 1'b1;
      end
      `TAP_IR_HIGHZ: begin
        ctl.hiz = 1'b1;
      end
      default: begin
        ctl = '0;
      end
    endcase
    return ctl;
  endfunction : decode_test

  test_ctl_type test_ctl;

  // Standard controller transition on one rising test clock edge
  function automatic tap_state_type tap_next(input tap_state_type cur, input logic tms);
    tap_state_type nxt;
    nxt = cur;
    unique case (cur)
      TEST_LOGIC_RESET: begin
        nxt = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      end
      RUN_TEST_IDLE: begin
        nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
      SELECT_DR: begin
        nxt = tms ? SELECT_IR : CAPTURE_DR;
      end
      CAPTURE_DR: begin
        nxt = tms ? EXIT1_DR : SHIFT_DR;
      end
      SHIFT_DR: begin
        nxt = tms ? EXIT1_DR : SHIFT_DR;
      end
      EXIT1_DR: begin
        nxt = tms ? UPDATE_DR : PAUSE_DR;
      end
      PAUSE_DR: begin
        nxt = tms ? EXIT2_DR : PAUSE_DR;
      end
      EXIT2_DR: begin
        nxt = tms ? UPDATE_DR : SHIFT_DR;
      end
      UPDATE_DR: begin
        nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
      SELECT_IR: begin
        nxt = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      end
      CAPTURE_IR: begin
        nxt = tms ? EXIT1_IR : SHIFT_IR;
      end
      SHIFT_IR: begin
        nxt = tms ? EXIT1_IR : SHIFT_IR;
      end
      EXIT1_IR: begin
        nxt = tms ? UPDATE_IR : PAUSE_IR;
      end
      PAUSE_IR: begin
        nxt = tms ? EXIT2_IR : PAUSE_IR;
      end
      EXIT2_IR: begin
        nxt = tms ? UPDATE_IR : SHIFT_IR;
      end
      UPDATE_IR: begin
        nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
      end
    endcase
    return nxt;
  endfunction : tap_next

  tap_pin_sync #(
    .WIDTH     (`TAP_PIN_COUNT),
    .RESET_VAL (`TAP_PIN_RESET)
  ) u_pin_sync (
    .i_clock  (I_CLOCK),
    .i_rst_b  (I_RST_B),
    .i_clk_en (I_CLK_EN),
    .i_async  ({I_TRST_B, I_TDI, I_TMS, I_TCK}),
    .o_sync   (pins_sync)
  );

  assign tck_s    = pins_sync[0];
  assign tms_s    = pins_sync[1];
  assign tdi_s    = pins_sync[2];
  assign trst_b_s = pins_sync[3];

  assign tck_rise = tck_s & ~st_reg.tck_prev;
  assign tck_fall = ~tck_s & st_reg.tck_prev;
  assign dr_sel   = decode_dr(st_reg.ir_cur);
  assign test_ctl = decode_test(st_reg.ir_cur);

  // Boundary chain strobes, only while that chain is selected
  assign bsr_capture = tck_rise & (st_reg.state == CAPTURE_DR) &
                       (dr_sel == DR_BOUNDARY);
  assign bsr_shift   = tck_rise & (st_reg.state == SHIFT_DR) &
                       (dr_sel == DR_BOUNDARY);
  assign bsr_update  = tck_fall & (st_reg.state == UPDATE_DR) &
                       (dr_sel == DR_BOUNDARY);

  tap_scan_chain #(
    .LENGTH (BSR_LENGTH)
  ) u_scan_chain (
    .i_clock   (I_CLOCK),
    .i_rst_b   (I_RST_B),
    .i_clk_en  (I_CLK_EN),
    .i_capture (bsr_capture),
    .i_shift   (bsr_shift),
    .i_update  (bsr_update),
    .i_sin     (tdi_s),
    .i_par_in  (I_BSR_CAPTURE),
    .o_sout    (bsr_sout),
    .o_par_out (O_BSR_DRIVE)
  );

  always_comb begin
    st_next          = st_reg;
    st_next.tck_prev = tck_s;

    if (tck_rise) begin
      st_next.state = tap_next(st_reg.state, tms_s);
      unique case (st_reg.state)
        CAPTURE_IR: begin
          st_next.ir_shift = `TAP_IR_CAPTURE;
        end
        SHIFT_IR: begin
          // Bit 0 sits next to the serial output
          st_next.ir_shift = {tdi_s, st_reg.ir_shift[`TAP_IR_WIDTH-1:1]};
        end
        CAPTURE_DR: begin
          if (dr_sel == DR_BYPASS) begin
            st_next.bypass = 1'b0;
          end
          if (dr_sel == DR_IDENT) begin
            st_next.id_shift = ID_VALUE;
          end
        end
        SHIFT_DR: begin
          if (dr_sel == DR_BYPASS) begin
            st_next.bypass = tdi_s;
          end
          if (dr_sel == DR_IDENT) begin
            st_next.id_shift = {tdi_s, st_reg.id_shift[`TAP_ID_WIDTH-1:1]};
          end
        end
        default: begin
          // Pause and other states hold every shift stage
          st_next.ir_shift = st_reg.ir_shift;
        end
      endcase
    end

    if (tck_fall) begin
      if (st_reg.state == UPDATE_IR) begin
        st_next.ir_cur = st_reg.ir_shift;
      end
      // Serial output changes only on the falling edge
      unique case (st_reg.state)
        SHIFT_IR: begin
          st_next.tdo      = st_reg.ir_shift[0];
          st_next.tdo_oe_b = 1'b0;
        end
        SHIFT_DR: begin
          unique case (dr_sel)
            DR_BOUNDARY: st_next.tdo = bsr_sout;
            DR_IDENT:    st_next.tdo = st_reg.id_shift[0];
            default:     st_next.tdo = st_reg.bypass;
          endcase
          st_next.tdo_oe_b = 1'b0;
        end
        default: begin
          st_next.tdo_oe_b = 1'b1;
        end
      endcase
    end

    // Test reset pin or reset state forces the identification instruction
    if (!trst_b_s) begin
      st_next.state = TEST_LOGIC_RESET;
    end
    if (!trst_b_s || st_reg.state == TEST_LOGIC_RESET) begin
      st_next.ir_cur   = `TAP_IR_IDCODE;
      st_next.tdo_oe_b = 1'b1;
    end

    st_next.test_reset   = (st_reg.state == TEST_LOGIC_RESET);
    st_next.pin_override = (st_reg.state != TEST_LOGIC_RESET) &&
                           test_ctl.pins;
    st_next.outputs_hiz  = (st_reg.state != TEST_LOGIC_RESET) &&
                           test_ctl.hiz;
    // External test keeps driving the pins while idling
    st_next.run_active   = (st_reg.state == RUN_TEST_IDLE) &&
                           test_ctl.run;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_reg <= ST_RESET;
    end else if (I_CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign O_TDO             = st_reg.tdo;
  assign O_TDO_OE_B        = st_reg.tdo_oe_b;
  assign O_PIN_OVERRIDE    = st_reg.pin_override;
  assign O_OUTPUTS_HIZ     = st_reg.outputs_hiz;
  assign O_TEST_RESET      = st_reg.test_reset;
  assign O_RUN_TEST_ACTIVE = st_reg.run_active;

endmodule : tap_controller

`default_nettype wire

// File: tap_host.sv
/*
  JTAG host model: drives test clock, mode select, serial data and test reset.
  Assumes the system clock paces it; test clock period 20 system clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module tap_host (
  input  wire logic i_clock,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_b,
  output var  logic o_tck,
  output var  logic o_tms,
  output var  logic o_tdi,
  output var  logic o_trst_b
);
  localparam int HALF = 10;
  initial begin
    o_tck = 1'h1;
    o_tms = 1'h1;
    o_tdi = 1'h0;
    o_trst_b = 1'h1;
  end
  // One test clock: fall, low phase, sample serial out, rise
  task automatic clk(input logic tms, input logic tdi, output logic tdo, output logic oe_b);
    @(posedge i_clock);
    o_tck <= 1'h0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (HALF) @(posedge i_clock);
    tdo = i_tdo;
    oe_b = i_tdo_oe_b;
    o_tck <= 1'h1;
    repeat (HALF - 1) @(posedge i_clock);
  endtask : clk
  // Full scan from Run-Test-Idle back to Run-Test-Idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic drv);
    logic t;
    logic o;
    dout = '0;
    drv = 1'h1;
    clk(1'h1, ~o_tdi, t, o);
    if (ir) clk(1'h1, ~o_tdi, t, o);
    clk(1'h0, ~o_tdi, t, o);
    clk(1'h0, ~o_tdi, t, o);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], dout[i], o);
      drv &= ~o;
    end
    clk(1'h1, ~o_tdi, t, o);
    clk(1'h0, ~o_tdi, t, o);
  endtask : scan
  task automatic tlr();
    logic t;
    logic o;
    repeat (5) clk(1'h1, ~o_tdi, t, o);
    clk(1'h0, ~o_tdi, t, o);
  endtask : tlr
  task automatic trst();
    @(posedge i_clock);
    o_trst_b <= 1'h0;
    repeat (4) @(posedge i_clock);
    o_trst_b <= 1'h1;
    repeat (8) @(posedge i_clock);
  endtask : trst
endmodule : tap_host
`default_nettype wire

// File: tap_controller_chk.sv
/*
  Assertions on the test access port outputs against its test pins.
  Assumes test clock phases of at least ten system clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module tap_controller_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TRST_B,
  input wire logic O_TDO,
  input wire logic O_TDO_OE_B,
  input wire logic O_PIN_OVERRIDE,
  input wire logic O_OUTPUTS_HIZ,
  input wire logic O_TEST_RESET,
  input wire logic O_RUN_TEST_ACTIVE
);
  typedef struct packed {
    logic       tck;
    logic [2:0] ones;
    logic [3:0] calm;
  } chk_state_type;
  chk_state_type state_reg;
  chk_state_type state_next;
  logic          quiet;
  // Rises with mode select high; cycles since test reset pin
  always_comb begin
    state_next = state_reg;
    state_next.tck = I_TCK;
    if (I_TCK && !state_reg.tck) begin
      state_next.ones = !I_TMS ? 3'h0 : (state_reg.ones == 3'h5) ? 3'h5 : state_reg.ones + 3'h1;
    end
    if (!I_TRST_B) begin
      state_next.calm = 4'h0;
    end else if (state_reg.calm != 4'hF) begin
      state_next.calm = state_reg.calm + 4'h1;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= '{1'h1, 3'h0, 4'h0};
    end else begin
      state_reg <= state_next;
    end
  end
  assign quiet = (state_reg.calm == 4'hF);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  sequence five_ones_s;
    state_reg.ones == 3'h5;
  endsequence
  sequence trst_held_s;
    !I_TRST_B [*4];
  endsequence
  tlr_quiet_a: assert property (O_TEST_RESET |-> !O_PIN_OVERRIDE && !O_OUTPUTS_HIZ)
    else $error("test logic active in reset state");
  flag_exclusive_a: assert property (!(O_PIN_OVERRIDE && O_OUTPUTS_HIZ))
    else $error("two instructions decoded at once");
  run_extest_a: assert property (O_RUN_TEST_ACTIVE |-> O_PIN_OVERRIDE && !O_TEST_RESET)
    else $error("run test active without its instruction");
  tlr_release_a: assert property (O_TEST_RESET && $past(O_TEST_RESET) |-> O_TDO_OE_B)
    else $error("serial out driven in reset state");
  tdo_fall_a: assert property ($changed(O_TDO) && quiet |-> !$past(I_TCK, 2))
    else $error("serial out changed after a rising test clock");
  oe_fall_a: assert property ($fell(O_TDO_OE_B) |-> !$past(I_TCK, 2))
    else $error("serial out enabled after a rising test clock");
  state_rise_a: assert property ($changed(O_TEST_RESET) && quiet |-> $past(I_TCK, 2))
    else $error("state changed after a falling test clock");
  trst_reset_a: assert property (trst_held_s |-> ##[0:4] O_TEST_RESET && O_TDO_OE_B)
    else $error("test reset pin did not reset the port");
  five_ones_a: assert property (five_ones_s |-> ##[0:8] O_TEST_RESET)
    else $error("five mode select ones did not reset");
endmodule : tap_controller_chk
bind tap_controller tap_controller_chk chk (
  .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_TCK(I_TCK), .I_TMS(I_TMS),
  .I_TRST_B(I_TRST_B), .O_TDO(O_TDO), .O_TDO_OE_B(O_TDO_OE_B),
  .O_PIN_OVERRIDE(O_PIN_OVERRIDE), .O_OUTPUTS_HIZ(O_OUTPUTS_HIZ),
  .O_TEST_RESET(O_TEST_RESET), .O_RUN_TEST_ACTIVE(O_RUN_TEST_ACTIVE)
);
`default_nettype wire

// File: tap_controller_tb_top.sv
/*
  Testbench of the test access port: instruction table, pause, resets.
  Assumes the host model paces the test clock; serial out has a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module tap_controller_tb_top;
  localparam logic [3:0]  VER   = 4'h3;     // Arbitrary value
  localparam logic [15:0] PART  = 16'h5A17; // Arbitrary value
  localparam logic [10:0] MAKER = 11'h0E5;  // Arbitrary value
  localparam logic [31:0] ID    = {VER, PART, MAKER, 1'h1};
  localparam logic [7:0]  CAP   = 8'h96;
  localparam logic [13:0] PTMS  = 14'h1923;
  typedef struct packed {
    logic [3:0]  code;
    logic [5:0]  n;
    logic [31:0] din;
    logic [31:0] exp;
    logic [7:0]  drv;
  } row_type;
  localparam row_type ROWS [7] = '{
    '{4'h2, 6'h20, 32'h0, ID, 8'h0},
    '{4'hF, 6'h04, 32'hB, 32'h6, 8'h0},
    '{4'h3, 6'h04, 32'hB, 32'h6, 8'h0},
    '{4'h5, 6'h04, 32'h9, 32'h2, 8'h0},
    '{4'hA, 6'h04, 32'h6, 32'hC, 8'h0},
    '{4'h1, 6'h10, 32'hA53C, 32'h3C96, 8'hA5},
    '{4'h0, 6'h10, 32'h5AC3, 32'hC396, 8'h5A}};
  logic       clock;
  logic       rst_b;
  logic       clk_en;
  logic       tck, tms, tdi, trst_b, tdo, tdo_oe_b, tdo_line;
  logic       pin_ovr, hiz, test_rst, run_act, t, o;
  logic [7:0] bsr_drive;
  logic [3:0] got;
  int         errors;
  int         tests_run;
  assign tdo_line = tdo_oe_b ? 1'h1 : tdo;
  tap_controller #(.BSR_LENGTH(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
    .I_CLOCK(clock), .I_RST_B(rst_b), .I_CLK_EN(clk_en), .I_TCK(tck), .I_TMS(tms),
    .I_TDI(tdi), .I_TRST_B(trst_b), .I_BSR_CAPTURE(CAP), .O_TDO(tdo),
    .O_TDO_OE_B(tdo_oe_b), .O_BSR_DRIVE(bsr_drive), .O_PIN_OVERRIDE(pin_ovr),
    .O_OUTPUTS_HIZ(hiz), .O_TEST_RESET(test_rst), .O_RUN_TEST_ACTIVE(run_act));
  tap_host host (.i_clock(clock), .i_tdo(tdo_line), .i_tdo_oe_b(tdo_oe_b), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_b(trst_b));
  always #2 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ir(input logic [3:0] code);
    logic [31:0] d;
    logic        ok;
    host.scan(1'h1, 4, {28'h0, code}, d, ok);
    check(d, 32'h1);
    check(32'(ok), 32'h1);
  endtask : ir
  task automatic dr(input int n, input logic [31:0] din, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host.scan(1'h0, n, din, d, ok);
    check(d, exp);
    check(32'(ok), 32'h1);
  endtask : dr
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    clock = 1'h0;
    rst_b = 1'h0;
    clk_en = 1'h1;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    check(32'(test_rst), 32'h1);
    rst_b <= 1'h1;
    repeat (8) @(posedge clock);
    host.tlr();
    dr(32, 32'h0, ID);
    foreach (ROWS[i]) begin
      ir(ROWS[i].code);
      dr(ROWS[i].n, ROWS[i].din, ROWS[i].exp);
      check(32'(pin_ovr), 32'(ROWS[i].code == 4'h0));
      check(32'(hiz), 32'(ROWS[i].code == 4'h3));
      check(32'(run_act), 32'(ROWS[i].code == 4'h0));
      if (ROWS[i].code < 4'h2) check(32'(bsr_drive), 32'(ROWS[i].drv));
    end
    // Instruction scan with a pause in the middle
    got = 4'h0;
    for (int i = 0; i < 14; i++) begin
      host.clk(PTMS[i], 1'h1, t, o);
      if (i inside {4, 5, 10, 11}) got = {t, got[3:1]};
    end
    check(32'(got), 32'h1);
    dr(4, 32'hB, 32'h6);
    repeat (3) host.clk(1'h1, 1'h0, t, o);
    check(32'(test_rst), 32'h1);
    host.clk(1'h0, 1'h0, t, o);
    check(32'(test_rst), 32'h0);
    // Five ones from the middle of a data scan
    ir(4'h0);
    host.clk(1'h1, 1'h0, t, o);
    repeat (2) host.clk(1'h0, 1'h0, t, o);
    repeat (5) host.clk(1'h1, 1'h0, t, o);
    check(32'(test_rst), 32'h1);
    check(32'(pin_ovr), 32'h0);
    host.clk(1'h0, 1'h0, t, o);
    dr(32, 32'h0, ID);
    // Frozen port must ignore three mode select ones
    clk_en <= 1'h0;
    repeat (3) host.clk(1'h1, 1'h0, t, o);
    clk_en <= 1'h1;
    repeat (2) @(posedge clock);
    check(32'(test_rst), 32'h0);
    host.clk(1'h0, 1'h0, t, o);
    ir(4'h0);
    host.trst();
    check(32'(test_rst), 32'h1);
    check(32'(pin_ovr), 32'h0);
    host.clk(1'h0, 1'h0, t, o);
    dr(32, 32'h0, ID);
    finish_test();
  end
endmodule : tap_controller_tb_top
`default_nettype wire
